// *** verilog/agm_pkg.sv ***
// Package for the auto gain matching control block
// Assumes a single 20 MHz clock and a byte-wide register port
package agm_pkg;
   // Register map and field layout
   localparam logic [7:0] GAIN_CTRL_OFS   = 8'h3c;     // Control register
   localparam logic [7:0] GAIN_STAT_OFS   = 8'h3d;     // Status register
   localparam logic [7:0] UPD_INTV_OFS    = 8'h3e;     // Interval, in hsyncs
   localparam int         HOLD_BIT        = 3;         // Hold bit position
   localparam logic [2:0] ENA_OFF         = 3'b000;    // Function disabled
   localparam logic [2:0] ENA_ON          = 3'b110;    // Function enabled
   localparam logic [7:0] GAIN_CTRL_RST   = 8'h00;     // Hold 0 after reset
   localparam logic [7:0] UPD_INTV_RST    = 8'h40;     // 64 hsyncs per update
   localparam logic [3:0] SETTLE_UPDATES  = 4'ha;      // Settled within ten
   localparam int         GAIN_W          = 8;         // Correction width
   localparam logic [7:0] GAIN_MID        = 8'h80;     // Unity correction
   localparam int         NCH             = 3;         // Channels

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   // Correction words for all channels
   typedef logic [NCH-1:0][GAIN_W-1:0] gain_vec_t;

   // Loop state, gray coded along the usual path
   typedef enum logic [1:0] {
      ST_OFF    = 2'b00,
      ST_TRACK  = 2'b01,
      ST_FROZEN = 2'b11
   } agm_state_t;
endpackage

// *** verilog/gain_step.sv ***
// One channel of the gain loop: steps correction toward a target
// Assumes the caller pulses step only on update events
`timescale 1ns/10ps
module gain_step
   import agm_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              step,
   input  wire logic [GAIN_W-1:0] target,
   output logic      [GAIN_W-1:0] gain
);
   logic [GAIN_W-1:0] gain_q; // Current correction
   logic [GAIN_W-1:0] gain_d; // Halfway toward target
   logic [GAIN_W:0]   sum;    // Wide sum to avoid overflow

   // Binary approach: converges in at most nine steps
   always_comb
   begin
      sum    = {1'b0, gain_q} + {1'b0, target} + 9'h001;
      gain_d = sum[GAIN_W:1];
      if (gain_d == gain_q)
      begin
         gain_d = target;
      end
   end

   // Correction register
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         gain_q <= GAIN_MID;
      else if (step)
         gain_q <= gain_d;
   end

   assign gain = gain_q;
endmodule // gain_step

// *** verilog/auto_gain_match_control.sv ***
// Auto gain matching control: register, update pacing, gain loop
// Assumes hsync_pulse is a one-cycle strobe synchronous to clk
// Assumes gain_target is steady between update events
//
// How it works
// - Hold one: recompute gains every update event
// - Hold zero: freeze last computed gains
// - Hold bit resets to zero
// - Enable field 000 off, 110 on
// - Loop settles within ten update events
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
module auto_gain_match_control
   import agm_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  agm_pkg::reg_req_t         req,
   output logic      [7:0]           rdata,
   input  wire logic                 hsync_pulse,
   input  agm_pkg::gain_vec_t        gain_target,
   output agm_pkg::gain_vec_t        gain_out,
   output logic                      gain_active,
   output logic                      settled
);
   // Whole package visible in the body
   import agm_pkg::*;

   // Software visible registers
   logic [7:0]  ctrl_q;      // Control register
   logic [7:0]  intv_q;      // Hsyncs per update event

   // Update pacing and settle count
   logic [7:0]  hcnt_q;      // Hsync counter
   logic        upd_q;       // Update event pulse
   logic [3:0]  nupd_q;      // Update events since tracking began

   // Values on their way out
   logic [7:0]  rdata_q;     // Read data register
   logic        act_q;       // Registered enable status
   logic        set_q;       // Registered settled status
   gain_vec_t   gain_q;      // Output copy of corrections
   gain_vec_t   gain_w;      // Corrections from channel loops

   // Loop control
   agm_state_t  st_q;        // Loop state
   logic        enabled;     // Enable field decoded
   logic        step;        // Channel step strobe

   // Decode the enable field; any code but the on code means off,
   // so a half-written field never starts the loop
   function automatic logic ena_dec(input logic [7:0] c);
      ena_dec = (c[2:0] == ENA_ON);
   endfunction

   assign enabled = ena_dec(ctrl_q);

   // Register writes; they take effect at the next edge
   always_ff @(posedge clk)
   begin
      // Reset: hold bit clear, so corrections stay frozen
      if (sys_rst)
      begin
         ctrl_q <= GAIN_CTRL_RST;
         intv_q <= UPD_INTV_RST;
      end
      // Mapped writes only; others are dropped
      else if (req.wr)
      begin
         // Upper bits kept as written
         if (req.addr == GAIN_CTRL_OFS)
            ctrl_q <= req.wdata;
         // New interval applies from the next count
         else if (req.addr == UPD_INTV_OFS)
            intv_q <= req.wdata;
      end
   end

   // Register reads, answer one cycle later; unmapped reads zero
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rdata_q <= 8'h00;
      // Read strobe: latch the addressed register
      else if (req.rd)
      begin
         // Status packs the low count bits beside the state
         case (req.addr)
            GAIN_CTRL_OFS: rdata_q <= ctrl_q;
            GAIN_STAT_OFS: rdata_q <= {4'h0, nupd_q[1:0], st_q};
            UPD_INTV_OFS:  rdata_q <= intv_q;
            default:       rdata_q <= 8'h00;
         endcase
      end
      // No read: bus idles at zero, stale data never shows
      else
         rdata_q <= 8'h00;
   end

   // Update event pacing from hsyncs, idle while disabled; the
   // eight-bit counter limits the interval to 255 hsyncs
   always_ff @(posedge clk)
   begin
      // Parked while off, so the first event after enabling
      // comes only after a full interval
      if (sys_rst || !enabled)
      begin
         hcnt_q <= 8'h00;
         upd_q  <= 1'b0;
      end
      // Count hsyncs toward the next event
      else if (hsync_pulse)
      begin
         // Interval of zero treated as one
         if (hcnt_q + 8'h01 >= intv_q)
         begin
            // Last hsync of the interval: one event
            hcnt_q <= 8'h00;
            upd_q  <= 1'b1;
         end
         else
         begin
            // Still inside the interval
            hcnt_q <= hcnt_q + 8'h01;
            upd_q  <= 1'b0;
         end
      end
      // No hsync: event pulse lasts one cycle only
      else
         upd_q <= 1'b0;
   end

   // Loop state follows enable and hold bit; the hold bit only
   // matters while the function is enabled
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         st_q <= ST_OFF;
      else
      begin
         case (st_q)
            // Off: the hold bit picks the state once enabled
            ST_OFF:
               if (enabled)
                  st_q <= ctrl_q[HOLD_BIT] ? ST_TRACK : ST_FROZEN;
            // Tracking: leave on disable or on hold cleared
            ST_TRACK:
               if (!enabled)
                  st_q <= ST_OFF;
               else if (!ctrl_q[HOLD_BIT])
                  st_q <= ST_FROZEN;
            // Frozen: last corrections stay applied
            ST_FROZEN:
               if (!enabled)
                  st_q <= ST_OFF;
               else if (ctrl_q[HOLD_BIT])
                  st_q <= ST_TRACK;
            // Unused code falls back to off
            default:
               st_q <= ST_OFF;
         endcase
      end
   end

   // Corrections move only on update events while tracking; enabled
   // is gated again so a pulse in flight at switch-off does nothing
   assign step = upd_q && (st_q == ST_TRACK) && enabled;

   // Count update events to flag settling; cleared whenever tracking
   // stops, so each calibration counts from zero, and held at the
   // settle count so it never wraps
   always_ff @(posedge clk)
   begin
      if (sys_rst || st_q != ST_TRACK)
         nupd_q <= 4'h0;
      else if (step && nupd_q != SETTLE_UPDATES)
         nupd_q <= nupd_q + 4'h1;
   end

   // One loop per channel; nine halvings fit in ten events
   // All channels share one strobe, so they settle together
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++)
      begin : g_ch
         gain_step u_step (
            .clk     (clk),
            .sys_rst (sys_rst),
            .step    (step),
            .target  (gain_target[ch]),
            .gain    (gain_w[ch])
         );
      end
   endgenerate

   // Registered outputs
   always_ff @(posedge clk)
   begin
      // Reset: unity corrections, status low
      if (sys_rst)
      begin
         gain_q <= {NCH{GAIN_MID}};
         act_q  <= 1'b0;
         set_q  <= 1'b0;
      end
      // Settled: frozen, or tracking for the full settle count
      else
      begin
         // Copied every cycle; they move only on a step
         gain_q <= gain_w;
         act_q  <= enabled;
         set_q  <= (st_q == ST_FROZEN) || (nupd_q == SETTLE_UPDATES);
      end
   end

   // Ports straight from the output flops
   assign rdata       = rdata_q;
   assign gain_out    = gain_q;
   assign gain_active = act_q;
   assign settled     = set_q;
endmodule // auto_gain_match_control

// *** tb/agm_monitor.sv ***
// Port checker for the auto gain matching control
// Assumes it is bound onto auto_gain_match_control
`timescale 1ns/10ps
module agm_monitor
   import agm_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  agm_pkg::reg_req_t req,
   input  wire logic [7:0]   rdata,
   input  wire logic         hsync_pulse,
   input  agm_pkg::gain_vec_t gain_target,
   input  agm_pkg::gain_vec_t gain_out,
   input  wire logic         gain_active,
   input  wire logic         settled
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Corrections move only three edges after an hsync
   property p_move;
      !$past(hsync_pulse, 3) |-> $stable(gain_out);
   endproperty
   a_move: assert property (p_move) else $error("gain moved");
   // Active flag follows the enable field
   property p_act;
      req.wr && req.addr == GAIN_CTRL_OFS
         |-> ##2 gain_active == ($past(req.wdata[2:0], 2) == ENA_ON);
   endproperty
   a_act: assert property (p_act) else $error("active wrong");
   // Disabled loop leaves corrections alone
   property p_off;
      !gain_active [*4] |-> $stable(gain_out);
   endproperty
   a_off: assert property (p_off) else $error("moved while off");
   // Read data only after a read
   property p_idle;
      !$past(req.rd) |-> rdata == 8'h00;
   endproperty
   a_idle: assert property (p_idle) else $error("rdata not idle");
   // Reset leaves unity gains, loop inactive
   property p_rst;
      $fell(sys_rst) |-> gain_out == {NCH{GAIN_MID}} && !gain_active;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   // Settling only reported for an enabled loop
   property p_setl;
      $rose(settled) |-> $past(gain_active);
   endproperty
   a_setl: assert property (p_setl) else $error("settled idle");
endmodule // agm_monitor

bind auto_gain_match_control agm_monitor agm_monitor_i (.clk, .sys_rst,
   .req, .rdata, .hsync_pulse, .gain_target, .gain_out, .gain_active,
   .settled);

// *** tb/testbench.sv ***
// Self-checking bench for the auto gain matching control
// Assumes the package, design and checker are compiled first
`timescale 1ns/10ps
module testbench;
   import agm_pkg::*;
   logic      clk = 0;       // 20 MHz clock
   logic      sys_rst = 1;   // Sync reset
   reg_req_t  req = '0;      // Register port
   logic [7:0] rdata;        // Read data
   logic      hsync = 0;     // Hsync strobe
   gain_vec_t tgt = '0;      // Target corrections
   gain_vec_t gain, old;     // Applied and remembered gains
   logic      act, setl;     // Status outputs
   int        bad_count = 0;
   int        samples_checked = 0;
   logic [7:0] lfsr = 8'h1b; // Random source
   always #25 clk = ~clk;
   auto_gain_match_control auto_gain_match_control_i (.clk, .sys_rst,
      .req, .rdata, .hsync_pulse(hsync), .gain_target(tgt),
      .gain_out(gain), .gain_active(act), .settled(setl));
   // Compare and count
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   // One-cycle register write
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask
   // One-cycle register read, data in next cycle
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '0;
      #1 check({16'h0000, rdata}, {16'h0000, exp});
      @(posedge clk);
   endtask
   // Hsync strobes four cycles apart
   task automatic pulses(input int n);
      @(posedge clk);
      repeat (n)
      begin
         hsync <= 1'b1;
         @(posedge clk);
         hsync <= 1'b0;
         repeat (3) @(posedge clk);
      end
      #1;
   endtask
   // Next value of the random source
   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      lfsr_next = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   // New random targets
   task automatic newtgt;
      for (int i = 0; i < NCH; i++)
      begin
         lfsr = lfsr_next(lfsr);
         tgt[i] <= lfsr;
      end
   endtask
   // Verdict and end of run
   task automatic results;
      $display("checked %0d bad %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #100000;
      bad_count++;
      results();
   end
   // Main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(GAIN_CTRL_OFS, GAIN_CTRL_RST);
      rd(8'h10, 8'h00);
      newtgt();
      wr(UPD_INTV_OFS, 8'h01);
      wr(GAIN_CTRL_OFS, 8'h08);
      pulses(12);
      check(gain, {NCH{GAIN_MID}});
      wr(GAIN_CTRL_OFS, 8'h0e);
      rd(GAIN_CTRL_OFS, 8'h0e);
      pulses(10);
      check(gain, tgt);
      check(setl, 1'b1);
      wr(GAIN_CTRL_OFS, 8'h06);
      old = tgt;
      newtgt();
      pulses(10);
      check(gain, old);
      check(setl, 1'b1);
      rd(GAIN_STAT_OFS, {6'h00, ST_FROZEN});
      wr(GAIN_CTRL_OFS, 8'h0e);
      pulses(10);
      check(gain, tgt);
      old = tgt;
      newtgt();
      wr(GAIN_CTRL_OFS, 8'h08);
      pulses(5);
      check(gain, old);
      check(act, 1'b0);
      wr(UPD_INTV_OFS, 8'h03);
      wr(GAIN_CTRL_OFS, 8'h0e);
      pulses(2);
      check(gain, old);
      check(setl, 1'b0);
      pulses(28);
      check(gain, tgt);
      check(setl, 1'b1);
      rd(GAIN_STAT_OFS, {4'h0, SETTLE_UPDATES[1:0], ST_TRACK});
      rd(UPD_INTV_OFS, 8'h03);
      results();
   end
endmodule // testbench
